/* core/driver_ctrl_status_reg0.sv */
// Serial control word 0 and fault flag register 0 of the actuator driver
`timescale 1ns/1ps
module driver_ctrl_status_reg0
  import drv_reg0_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC               // Start-up wait in clocks
)
(
  input  wire logic                         MCLK,
  input  wire logic                         RSTN,
  input  wire logic                         CHIP_SELECT_LOW,      // Frame select, low active
  input  wire logic                         SERIAL_CLK,           // Link clock pin
  input  wire logic                         SERIAL_INPUT,         // Data in, LSB first
  output logic                              SERIAL_OUTPUT,        // Status data out
  output logic                              SERIAL_OUTPUT_EN,     // Drives data out pin
  input  wire logic                         UNDERVOLT_IN,         // Supply undervoltage
  input  wire logic                         OVERVOLT_IN,          // Supply overvoltage
  input  wire logic                         THERMAL_SHUTDOWN_IN,  // Junction too hot
  input  wire logic                         TEMP_WARNING_IN,      // Junction warm
  input  wire logic [drv_reg0_pkg::NUM_HS-1:0] OVERCURRENT_IN,    // Per output seven..eleven
  input  wire logic [drv_reg0_pkg::NUM_HS-1:0] OC_RECOVERY_EN,    // Retry enable per output
  output logic [drv_reg0_pkg::NUM_HS-1:0]   HIGH_SIDE_SWITCH,     // Outputs seven..eleven on
  output logic [4:0]                        CURRENT_IMAGE_OUTPUT, // One-hot monitor source
  output logic                              THERMAL_SHUTDOWN_FLAG,// Latched thermal flag
  output logic                              NOT_READY             // Start-up in progress
);
  import drv_reg0_pkg::*;

  localparam int PHASE_W = $clog2(RECOV_PERIOD_CYC);
  localparam int TMR_W   = $clog2(STARTUP_CYCLES + 1);

  logic [1:0]        rst_sync_r;                 // Reset release chain
  logic              rst_n;                      // Released reset
  logic [1:0]        cs_sync_r, ck_sync_r, di_sync_r; // Pin synchronisers
  logic              cs_d_r, ck_d_r;             // Delayed copies for edges
  logic [8:0]        flt_sync1_r, flt_sync2_r;   // Fault input synchronisers
  logic              uv_now, ov_now, tsd_now, tw_now;
  logic [NUM_HS-1:0] oc_now;
  logic              cs_fall, cs_rise, ck_rise, ck_fall;
  logic [23:0]       shift_in_r;                 // Received bits
  logic [4:0]        bit_cnt_r;                  // Saturating bit count
  logic [23:0]       shift_out_r;                // Status being sent
  logic [23:0]       ctrl_r;                     // Control word 0
  logic              frame_ok;                   // Exact-length frame to reg 0
  logic              flag_clr;                   // Clear pulse at frame end
  logic              uv_flag_r, ov_flag_r, tw_flag_r, tsd_flag_r;
  logic [NUM_HS-1:0] oc_flag;
  logic [NUM_HS-1:0] hs_drive;
  logic [23:0]       status;                     // Assembled fault flags
  pwr_state_t        pwr_r;                      // Power sequencing state
  logic [TMR_W-1:0]  tmr_r;                      // Start-up countdown
  logic [PHASE_W-1:0] phase_r;                   // Retry period phase
  logic              retry_on;
  logic              supply_block, allowed;
  logic [4:0]        mon_nxt;

  // Reset released through two flip-flops
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Link pins pass two flip-flops
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_sync_r <= 2'b11;
      ck_sync_r <= 2'b00;
      di_sync_r <= 2'b00;
      cs_d_r    <= 1'b1;
      ck_d_r    <= 1'b0;
    end
    else
    begin
      cs_sync_r <= {cs_sync_r[0], CHIP_SELECT_LOW};
      ck_sync_r <= {ck_sync_r[0], SERIAL_CLK};
      di_sync_r <= {di_sync_r[0], SERIAL_INPUT};
      cs_d_r    <= cs_sync_r[1];
      ck_d_r    <= ck_sync_r[1];
    end
  end
  assign cs_fall = cs_d_r & ~cs_sync_r[1];
  assign cs_rise = ~cs_d_r & cs_sync_r[1];
  assign ck_rise = ~ck_d_r & ck_sync_r[1] & ~cs_sync_r[1];
  assign ck_fall = ck_d_r & ~ck_sync_r[1] & ~cs_sync_r[1];

  // Fault pins pass two flip-flops
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flt_sync1_r <= 9'h000;
      flt_sync2_r <= 9'h000;
    end
    else
    begin
      flt_sync1_r <= {OVERCURRENT_IN, TEMP_WARNING_IN, THERMAL_SHUTDOWN_IN,
                      OVERVOLT_IN, UNDERVOLT_IN};
      flt_sync2_r <= flt_sync1_r;
    end
  end
  assign uv_now  = flt_sync2_r[0];
  assign ov_now  = flt_sync2_r[1];
  assign tsd_now = flt_sync2_r[2];
  assign tw_now  = flt_sync2_r[3];
  assign oc_now  = flt_sync2_r[8:4];

  // Receive: sample on link clock rise, count bits
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_in_r <= 24'h000000;
      bit_cnt_r  <= 5'h00;
    end
    else if (cs_fall)
      bit_cnt_r  <= 5'h00;
    else if (ck_rise)
    begin
      shift_in_r <= {di_sync_r[1], shift_in_r[23:1]};
      if (bit_cnt_r <= 5'(FRAME_BITS))
        bit_cnt_r <= bit_cnt_r + 5'h01;           // Stops one past valid length
    end
  end

  // Frame taken only at exact length and register 0 selected
  assign frame_ok = cs_rise && (bit_cnt_r == 5'(FRAME_BITS))
                    && !shift_in_r[CW_SELECT];
  assign flag_clr = frame_ok & shift_in_r[CW_STATUS_CLR];

  // Control word 0; clearing enable clears everything
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= CW_RESET;
    else if (frame_ok)
      ctrl_r <= shift_in_r[CW_ENABLE] ? shift_in_r : CW_RESET;
  end

  // Transmit: load status at frame start, shift on link clock fall
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_out_r      <= 24'h000000;
      SERIAL_OUTPUT    <= 1'b0;
      SERIAL_OUTPUT_EN <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_out_r      <= {1'b0, status[23:1]};
      SERIAL_OUTPUT    <= status[0];
      SERIAL_OUTPUT_EN <= 1'b1;
    end
    else if (cs_rise)
      SERIAL_OUTPUT_EN <= 1'b0;
    else if (ck_fall)
    begin
      SERIAL_OUTPUT    <= shift_out_r[0];
      shift_out_r      <= {1'b0, shift_out_r[23:1]};
    end
  end

  // Supply and temperature flags, latched, set wins over clear
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      uv_flag_r  <= 1'b0;
      ov_flag_r  <= 1'b0;
      tw_flag_r  <= 1'b0;
      tsd_flag_r <= 1'b0;
    end
    else
    begin
      uv_flag_r  <= (uv_flag_r  & ~flag_clr) | uv_now;
      ov_flag_r  <= (ov_flag_r  & ~flag_clr) | ov_now;
      tw_flag_r  <= (tw_flag_r  & ~flag_clr) | tw_now;
      tsd_flag_r <= (tsd_flag_r & ~flag_clr) | tsd_now;
    end
  end

  // Power sequencing with start-up countdown
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_r <= PWR_STANDBY;
      tmr_r <= '0;
    end
    else if (!ctrl_r[CW_ENABLE])
      pwr_r <= PWR_STANDBY;
    else
    begin
      case (pwr_r)
        PWR_STANDBY:
        begin
          pwr_r <= PWR_STARTING;
          tmr_r <= TMR_W'(STARTUP_CYCLES - 1);
        end
        PWR_STARTING:
        begin
          if (tmr_r == '0)
            pwr_r <= PWR_ACTIVE;
          else
            tmr_r <= tmr_r - TMR_W'(1);
        end
        PWR_ACTIVE:
          pwr_r <= PWR_ACTIVE;
        default:
          pwr_r <= PWR_STANDBY;
      endcase
    end
  end

  // Retry period phase, on-window set by duty select
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      phase_r <= '0;
    else if (phase_r == PHASE_W'(RECOV_PERIOD_CYC - 1))
      phase_r <= '0;
    else
      phase_r <= phase_r + PHASE_W'(1);
  end
  assign retry_on = ctrl_r[CW_DUTY_SEL] ? (phase_r < PHASE_W'(RECOV_ON_HIGH_CYC))
                                        : (phase_r < PHASE_W'(RECOV_ON_LOW_CYC));

  // Output permission; warning flag deliberately not used
  assign supply_block = uv_now | ov_now
                      | (ctrl_r[CW_SUPPLY_NOREC] & (uv_flag_r | ov_flag_r));
  assign allowed = (pwr_r == PWR_ACTIVE) & ~supply_block
                 & ~tsd_flag_r & ~tsd_now;

  // One channel per high-side output seven to eleven
  genvar g;
  generate
    for (g = 0; g < NUM_HS; g++)
    begin : gen_hs
      hs_channel u_ch
      (
        .clk        (MCLK),
        .rst_n      (rst_n),
        .switch_req (ctrl_r[CW_HS_LO + g]),
        .allowed    (allowed),
        .oc_event   (oc_now[g]),
        .recov_en   (OC_RECOVERY_EN[g]),
        .retry_on   (retry_on),
        .flag_clr   (flag_clr),
        .drive_r    (hs_drive[g]),
        .oc_flag_r  (oc_flag[g])
      );
    end
  endgenerate
  assign HIGH_SIDE_SWITCH = hs_drive;

  // Fault flag register assembly
  always_comb
  begin
    status                           = 24'h000000;
    status[SF_ALWAYS_ONE]            = 1'b1;
    status[SF_OVERVOLT]              = ov_flag_r;
    status[SF_UNDERVOLT]             = uv_flag_r;
    status[SF_THERMAL]               = tsd_flag_r;
    status[SF_TEMP_WARN]             = tw_flag_r;
    status[SF_NOT_READY]             = (pwr_r == PWR_STARTING);
    status[SF_HS_LO +: NUM_HS]       = oc_flag;
    status[SF_NO_ERROR]              = ~|status[22:1];
  end

  // Current monitor source select
  always_comb
  begin
    mon_nxt = 5'h00;
    case ({ctrl_r[CW_MON_HI], ctrl_r[CW_MON_LO]})
      2'b00:   mon_nxt[MON_ELEVEN] = 1'b1;
      2'b10:
      begin
        if (ctrl_r[CW_HB1_HS] && !ctrl_r[CW_HB6_HS])
          mon_nxt[MON_ONE] = 1'b1;
        else
          mon_nxt[MON_SIX] = 1'b1;
      end
      2'b01:   mon_nxt[MON_FIVE] = 1'b1;
      default: mon_nxt[MON_FOUR] = 1'b1;
    endcase
  end

  // Registered status outputs
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      CURRENT_IMAGE_OUTPUT  <= 5'h00;
      THERMAL_SHUTDOWN_FLAG <= 1'b0;
      NOT_READY             <= 1'b0;
    end
    else
    begin
      CURRENT_IMAGE_OUTPUT  <= mon_nxt;
      THERMAL_SHUTDOWN_FLAG <= tsd_flag_r;
      NOT_READY             <= (pwr_r == PWR_STARTING);
    end
  end
endmodule

/* common/drv_reg0_pkg.sv */
// Constants for the driver control word and fault flag register
package drv_reg0_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_PS     = 25000;                  // MCLK period, 40 MHz
  localparam int STARTUP_TIME_NS   = 50000;                  // Charge pump settle time
  localparam int STARTUP_CYC       = (STARTUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOV_PERIOD_NS   = 10000;                  // Over-current retry period
  localparam int RECOV_PERIOD_CYC  = (RECOV_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int DUTY_LOW_PCT      = 12;                     // Retry duty, select 0
  localparam int DUTY_HIGH_PCT     = 25;                     // Retry duty, select 1
  localparam int RECOV_ON_LOW_CYC  = RECOV_PERIOD_CYC * DUTY_LOW_PCT / 100;
  localparam int RECOV_ON_HIGH_CYC = RECOV_PERIOD_CYC * DUTY_HIGH_PCT / 100;
  // Frame
  localparam int FRAME_BITS        = 24;                     // Exact valid frame length
  localparam int NUM_HS            = 5;                      // Outputs seven to eleven
  // Control word fields
  localparam int CW_SELECT         = 0;                      // Register select bit
  localparam int CW_HB1_HS         = 2;                      // Half bridge one high side
  localparam int CW_HB6_HS         = 12;                     // Half bridge six high side
  localparam int CW_HS_LO          = 13;                     // Output seven switch
  localparam int CW_MON_LO         = 18;                     // Monitor select, low bit
  localparam int CW_MON_HI         = 19;                     // Monitor select, high bit
  localparam int CW_SUPPLY_NOREC   = 20;                     // Supply recovery disable
  localparam int CW_DUTY_SEL       = 21;                     // Retry duty select
  localparam int CW_STATUS_CLR     = 22;                     // Clear all flags
  localparam int CW_ENABLE         = 23;                     // Active when set
  localparam logic [23:0] CW_RESET = 24'h000000;             // Starts in standby
  // Fault flag fields
  localparam int SF_NO_ERROR       = 0;
  localparam int SF_HS_LO          = 13;                     // Output seven over-current
  localparam int SF_NOT_READY      = 18;
  localparam int SF_TEMP_WARN      = 19;
  localparam int SF_THERMAL        = 20;
  localparam int SF_UNDERVOLT      = 21;
  localparam int SF_OVERVOLT       = 22;
  localparam int SF_ALWAYS_ONE     = 23;
  // Monitor one-hot positions
  localparam int MON_ELEVEN        = 0;
  localparam int MON_ONE           = 1;
  localparam int MON_SIX           = 2;
  localparam int MON_FIVE          = 3;
  localparam int MON_FOUR          = 4;
  // Power sequencing states, Gray along standby, starting, active
  typedef enum logic [1:0] {
    PWR_STANDBY  = 2'b00,
    PWR_STARTING = 2'b01,
    PWR_ACTIVE   = 2'b11
  } pwr_state_t;
endpackage

/* core/hs_channel.sv */
// One high-side channel: switch state, over-current latch and retry
`timescale 1ns/1ps
module hs_channel
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic switch_req,   // Control bit for this output
  input  wire logic allowed,      // Global output permission
  input  wire logic oc_event,     // Synchronised over-current
  input  wire logic recov_en,     // Automatic retry enabled
  input  wire logic retry_on,     // Retry window phase
  input  wire logic flag_clr,     // Status clear from frame
  output logic      drive_r,      // Driver on
  output logic      oc_flag_r     // Latched over-current
);
  // Over-current latch, set wins over clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oc_flag_r <= 1'b0;
    else
      oc_flag_r <= (oc_flag_r & ~flag_clr) | oc_event;
  end

  // Driver state: off on fault, pulsed when retry active
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      drive_r <= 1'b0;
    else if (oc_event)
      drive_r <= 1'b0;
    else if (oc_flag_r && !flag_clr)
      drive_r <= allowed & switch_req & recov_en & retry_on;
    else
      drive_r <= allowed & switch_req;
  end
endmodule

/* testbench/driver_ctrl_status_reg0_asserts.sv */
// Pin-level assertions for control word 0 and fault flags 0
`timescale 1ns/1ps
module driver_ctrl_status_reg0_asserts
  import drv_reg0_pkg::*;
#(
  parameter int STARTUP_CYCLES = 2000  // Start-up wait in clocks
)
(
  input wire logic                           MCLK,
  input wire logic                           RSTN,
  input wire logic                           CHIP_SELECT_LOW,
  input wire logic                           SERIAL_OUTPUT_EN,
  input wire logic                           UNDERVOLT_IN,
  input wire logic                           THERMAL_SHUTDOWN_IN,
  input wire logic                           TEMP_WARNING_IN,
  input wire logic [drv_reg0_pkg::NUM_HS-1:0] OVERCURRENT_IN,
  input wire logic [drv_reg0_pkg::NUM_HS-1:0] OC_RECOVERY_EN,
  input wire logic [drv_reg0_pkg::NUM_HS-1:0] HIGH_SIDE_SWITCH,
  input wire logic                           THERMAL_SHUTDOWN_FLAG,
  input wire logic                           NOT_READY
);
  int nr_cnt;  // Length of current not-ready stretch
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Count cycles with not-ready high
  always_ff @(posedge MCLK or negedge RSTN)
    if (!RSTN)
      nr_cnt <= 0;
    else
      nr_cnt <= NOT_READY ? nr_cnt + 1 : 0;
  AST_TSD_SET:
    assert property ($rose(THERMAL_SHUTDOWN_IN) |-> ##[1:6] THERMAL_SHUTDOWN_FLAG)
    else $error("Thermal flag late");
  AST_TSD_OFF:
    assert property (THERMAL_SHUTDOWN_FLAG [*3] |-> HIGH_SIDE_SWITCH == 5'h00)
    else $error("Output on under thermal flag");
  AST_TSD_HOLD:
    assert property ($fell(THERMAL_SHUTDOWN_FLAG) |->
                     CHIP_SELECT_LOW && !$past(CHIP_SELECT_LOW, 8))
    else $error("Thermal flag fell outside frame end");
  AST_NR_OFF:
    assert property (NOT_READY [*3] |-> HIGH_SIDE_SWITCH == 5'h00)
    else $error("Output on while not ready");
  AST_NR_LEN:
    assert property ($fell(NOT_READY) |->
                     nr_cnt >= STARTUP_CYCLES && nr_cnt <= STARTUP_CYCLES + 1)
    else $error("Start-up length wrong");
  AST_OE_ON:
    assert property ($fell(CHIP_SELECT_LOW) |-> ##[2:5] SERIAL_OUTPUT_EN)
    else $error("Data out not enabled");
  AST_OC_OFF:
    assert property ($rose(OVERCURRENT_IN[0]) && !OC_RECOVERY_EN[0]
                     |-> ##[2:6] !HIGH_SIDE_SWITCH[0])
    else $error("Output seven not off");
  AST_WARN:
    assert property ($rose(TEMP_WARNING_IN) |=> $stable(HIGH_SIDE_SWITCH) [*6])
    else $error("Warning changed outputs");
  AST_UV:
    assert property (UNDERVOLT_IN [*8] |-> HIGH_SIDE_SWITCH == 5'h00)
    else $error("Output on under undervoltage");
endmodule
bind driver_ctrl_status_reg0 driver_ctrl_status_reg0_asserts
  #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (.MCLK(MCLK), .RSTN(RSTN),
  .CHIP_SELECT_LOW(CHIP_SELECT_LOW), .SERIAL_OUTPUT_EN(SERIAL_OUTPUT_EN),
  .UNDERVOLT_IN(UNDERVOLT_IN), .THERMAL_SHUTDOWN_IN(THERMAL_SHUTDOWN_IN),
  .TEMP_WARNING_IN(TEMP_WARNING_IN), .OVERCURRENT_IN(OVERCURRENT_IN),
  .OC_RECOVERY_EN(OC_RECOVERY_EN), .HIGH_SIDE_SWITCH(HIGH_SIDE_SWITCH),
  .THERMAL_SHUTDOWN_FLAG(THERMAL_SHUTDOWN_FLAG), .NOT_READY(NOT_READY));

/* testbench/serial_master_model.sv */
// Serial bus master that frames words into the driver
`timescale 1ns/1ps
module serial_master_model
(
  input  wire logic clk,   // Bench clock, frame start
  input  wire logic sdo,   // Status bit from device
  output logic      csl,   // Frame select, low active
  output logic      sclk,  // Link clock, idle low
  output logic      sdi    // Data to device
);
  logic [23:0] rx;   // Captured status word
  event        got;  // Full frame finished
  // Idle link
  initial
  begin
    csl = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  // Send n bits LSB first, sample status late in high phase
  task automatic xfer(input logic [23:0] w, input int n);
    @(posedge clk);
    #3 csl = 1'b0;
    #125;
    for (int i = 0; i < n; i++)
    begin
      sdi = w[i % 24];
      #100 sclk = 1'b1;
      #99 rx[i % 24] = sdo;
      #1 sclk = 1'b0;
    end
    #100 csl = 1'b1;  // Word latched on select rise
    sdi = ~sdi;       // Released line shows no old value
    #150;
    if (n == 24)
      -> got;
  endtask
endmodule

/* testbench/driver_ctrl_status_reg0_bench.sv */
// Self-checking bench for control word 0 and fault flags 0
`timescale 1ns/1ps
module driver_ctrl_status_reg0_bench;
  import drv_reg0_pkg::*;
  localparam int NR = 200;  // Shortened start-up wait
  logic        mclk, rstn, uv, ov, thermal_shutdown_flag, tw, tflag, nr, sdo, sdo_en, csl, sclk, sdi;
  logic [4:0]  oc, rec, hs, hsr, mon;
  logic [23:0] flg, base;   // Expected flags, active word
  logic [23:0] st_q[$];     // Expected status words
  logic [3:0]  msel[6] = '{4'h0, 4'h4, 4'hC, 4'h9, 4'hB, 4'h8};  // Bits 19,18,12,2
  int          mpos[6] = '{MON_ELEVEN, MON_FIVE, MON_FOUR, MON_ONE, MON_SIX, MON_SIX};
  int          errors, total_checks, cnt;
  driver_ctrl_status_reg0 #(.STARTUP_CYCLES(NR)) dut_u (.MCLK(mclk), .RSTN(rstn),
    .CHIP_SELECT_LOW(csl), .SERIAL_CLK(sclk), .SERIAL_INPUT(sdi),
    .SERIAL_OUTPUT(sdo), .SERIAL_OUTPUT_EN(sdo_en), .UNDERVOLT_IN(uv),
    .OVERVOLT_IN(ov), .THERMAL_SHUTDOWN_IN(thermal_shutdown_flag), .TEMP_WARNING_IN(tw),
    .OVERCURRENT_IN(oc), .OC_RECOVERY_EN(rec), .HIGH_SIDE_SWITCH(hs),
    .CURRENT_IMAGE_OUTPUT(mon), .THERMAL_SHUTDOWN_FLAG(tflag), .NOT_READY(nr));
  serial_master_model mcu_u (.clk(mclk), .sdo(sdo), .csl(csl), .sclk(sclk), .sdi(sdi));
  // Clock, 25 ns
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #3;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Frame with its status note; a clearing frame empties the flag model
  task automatic frame(input logic [23:0] w, input int n = 24);
    if (n == 24)
      st_q.push_back({1'b1, flg[22:1], ~|flg[22:1]});
    mcu_u.xfer(w, n);
    tick(8);
    if (n == 24 && !w[0] && w[CW_STATUS_CLR])
      flg = 24'h000000;
  endtask
  // Status read back against oldest note
  always @(mcu_u.got)
    chk(mcu_u.rx, st_q.pop_front());
  // Hang guard, run is about 170 us
  initial
  begin
    #1000000;
    errors++;
    test_done();
  end
  initial
  begin
    {rstn, uv, ov, thermal_shutdown_flag, tw, oc, rec, flg} = '0;
    void'($urandom(1201));
    hsr = 5'($urandom) | 5'h01;
    base = {1'b1, 5'h00, hsr, 13'h0000};
    tick(6);
    chk({hs, mon, tflag, nr, sdo_en}, 24'h000000);
    rstn = 1'b1;
    tick(4);
    frame(base);
    chk({nr, hs}, {1'b1, 5'h00});
    tick(NR);
    chk({nr, hs}, {1'b0, hsr});
    for (int i = 0; i < 6; i++)
    begin
      frame(base | {4'h0, msel[i][3:2], 5'h00, msel[i][1], 9'h000, msel[i][0], 2'h0});
      chk(mon, 5'h01 << mpos[i]);
    end
    for (int n = 23; n < 26; n++)
    begin
      frame({23'h000000, n == 24}, n);
      chk(hs, hsr);
    end
    tw = 1'b1;
    flg[SF_TEMP_WARN] = 1'b1;
    tick(10);
    chk(hs, hsr);
    tw = 1'b0;
    thermal_shutdown_flag = 1'b1;
    flg[SF_THERMAL] = 1'b1;
    tick(10);
    chk({tflag, hs}, {1'b1, 5'h00});
    thermal_shutdown_flag = 1'b0;
    frame(base);
    chk({tflag, hs}, {1'b1, 5'h00});
    frame(base | 24'h400000);
    chk({tflag, hs}, {1'b0, hsr});
    for (int r = 0; r < 2; r++)
    begin
      frame(base | (24'(r) << CW_SUPPLY_NOREC));
      {ov, uv} = r ? 2'h2 : 2'h1;
      flg[r ? SF_OVERVOLT : SF_UNDERVOLT] = 1'b1;
      tick(10);
      chk(hs, 5'h00);
      {ov, uv} = 2'h0;
      tick(10);
      chk(hs, r ? 5'h00 : hsr);
      frame(base | (24'(r) << CW_SUPPLY_NOREC) | 24'h400000);
      chk(hs, hsr);
    end
    for (int m = 0; m < 3; m++)
    begin
      rec[0] = (m > 0);
      frame(base | (24'(m == 2) << CW_DUTY_SEL));
      oc[0] = 1'b1;
      flg[SF_HS_LO] = 1'b1;
      tick(10);
      oc[0] = 1'b0;
      tick(3);  // Fault pin clears its synchroniser, driver no longer forced off
      cnt = 0;
      repeat (RECOV_PERIOD_CYC)
      begin
        tick(1);
        cnt += hs[0];
      end
      chk(24'(cnt), 24'(m == 0 ? 0 : m == 1 ? RECOV_ON_LOW_CYC : RECOV_ON_HIGH_CYC));
      rec[0] = 1'b0;
      frame(base | 24'h400000);
      chk(hs, hsr);
    end
    // Back to standby, then a second start-up
    frame(24'h000000);
    chk({nr, hs}, 6'h00);
    frame(base);
    chk({nr, hs}, {1'b1, 5'h00});
    tick(NR);
    chk({nr, hs}, {1'b0, hsr});
    test_done();
  end
endmodule
